// ==== hbts_hub.sv ====
`timescale 1ns/1ps
`default_nettype none
`include "hbts_defs.svh"
module hbts_hub
(
  // Clock and reset
  input wire logic clk_i,
  input wire logic resetn_i,
  input wire logic ce_i,
  // User side
  input wire logic data_ok_i,
  input wire hbts_pkg::hbts_rs_t resp_sel_i,
  input wire logic hub_snoop_req_i,
  output logic hub_snoop_gnt_o,
  output logic req_valid_o,
  output hbts_pkg::hbts_addr_t req_addr_o,
  output logic [9:0] req_cmd_o,
  output hbts_pkg::hbts_data_t data_o,
  output logic data_valid_o,
  output hbts_pkg::hbts_snp_t snoop_o,
  // Link
  hbts_if.hub bus
);
  import hbts_pkg::*;
  typedef enum logic [2:0]
  {
    HBTS_H_IDLE = 3'b000,
    HBTS_H_REQ2 = 3'b001,
    HBTS_H_SNOOP = 3'b010,
    HBTS_H_TRDY = 3'b011,
    HBTS_H_DATA = 3'b100,
    HBTS_H_RESP = 3'b101
  } hbts_hst_t;
  hbts_hst_t st_ff;
  logic [1:0] ads_s_ff, lock_s_ff, hit_s_ff, modified_snoop_hit_s_ff;
  logic [3:0] astb_s_ff, dstb_s_ff;
  logic [13:0] alo_s1_ff, alo_s2_ff;
  logic [14:0] ahi_s1_ff, ahi_s2_ff;
  logic [4:0] cmd_s1_ff, cmd_s2_ff;
  logic [63:0] d_s1_ff, d_s2_ff;
  logic [3:0] inv_s1_ff, inv_s2_ff;
  logic dstb_prev_ff;
  logic [1:0] ph_ff;
  logic [2:0] dly_ff;
  logic locked_ff;
  logic gnt_ff, req_valid_ff, data_valid_ff;
  hbts_addr_t addr_ff;
  logic [9:0] cmd_ff;
  hbts_data_t data_ff;
  hbts_snp_t snp_ff;
  logic trdy_n_ff;
  hbts_rs_t rs_ff;
  // Legal codes only; anything else reads as normal data
  function automatic hbts_rs_t legal_rs(input hbts_rs_t c);
    case (c)
      `HBTS_RS_RETRY, `HBTS_RS_DEFER, `HBTS_RS_NODATA, `HBTS_RS_IWB, `HBTS_RS_NORMAL: legal_rs = c;
      default: legal_rs = `HBTS_RS_NORMAL;
    endcase
  endfunction : legal_rs
  assign hub_snoop_gnt_o = gnt_ff;
  assign req_valid_o = req_valid_ff;
  assign req_addr_o = addr_ff;
  assign req_cmd_o = cmd_ff;
  assign data_o = data_ff;
  assign data_valid_o = data_valid_ff;
  assign snoop_o = snp_ff;
  assign bus.target_data_ready_n = trdy_n_ff;
  assign bus.response_status_code_n = ~rs_ff;
  // Two-stage sync of every pin except data strobe groups 1 to 3; only stage two is read
  always_ff @(posedge clk_i or negedge resetn_i)
    if (!resetn_i)
    begin
      ads_s_ff <= 2'h3;
      lock_s_ff <= 2'h3;
      hit_s_ff <= 2'h3;
      modified_snoop_hit_s_ff <= 2'h3;
      astb_s_ff <= 4'hF;
      // Idle strobe levels, so no false data edge follows reset
      dstb_s_ff <= 4'hA;
      alo_s1_ff <= '1;
      alo_s2_ff <= '1;
      ahi_s1_ff <= '1;
      ahi_s2_ff <= '1;
      cmd_s1_ff <= '1;
      cmd_s2_ff <= '1;
      d_s1_ff <= '1;
      d_s2_ff <= '1;
      inv_s1_ff <= '1;
      inv_s2_ff <= '1;
    end
    else if (ce_i)
    begin
      ads_s_ff <= {ads_s_ff[0], bus.req_strobe_n};
      lock_s_ff <= {lock_s_ff[0], bus.bus_lock_n};
      hit_s_ff <= {hit_s_ff[0], bus.clean_snoop_hit_n};
      modified_snoop_hit_s_ff <= {modified_snoop_hit_s_ff[0], bus.modified_snoop_hit_n};
      astb_s_ff <= {astb_s_ff[1:0], bus.address_strobe_pair_n};
      dstb_s_ff <= {dstb_s_ff[1:0], bus.data_strobe_positive_n[0], bus.data_strobe_negative_n[0]};
      alo_s1_ff <= bus.addr_lo_n;
      alo_s2_ff <= alo_s1_ff;
      ahi_s1_ff <= bus.addr_hi_n;
      ahi_s2_ff <= ahi_s1_ff;
      cmd_s1_ff <= bus.request_command_lines_n;
      cmd_s2_ff <= cmd_s1_ff;
      d_s1_ff <= bus.host_data_lines_n;
      d_s2_ff <= d_s1_ff;
      inv_s1_ff <= bus.data_inversion_flags_n;
      inv_s2_ff <= inv_s1_ff;
    end
  // Lock window and hub snoop gating
  always_ff @(posedge clk_i or negedge resetn_i)
    if (!resetn_i)
    begin
      locked_ff <= 1'b0;
      gnt_ff <= 1'b0;
    end
    else if (ce_i)
    begin
      if (lock_s_ff[1])
        locked_ff <= 1'b0;
      else if (!ads_s_ff[1])
        locked_ff <= 1'b1;
      gnt_ff <= hub_snoop_req_i && !locked_ff && lock_s_ff[1];
    end
  always_ff @(posedge clk_i or negedge resetn_i)
    if (!resetn_i)
    begin
      st_ff <= HBTS_H_IDLE;
      ph_ff <= 2'h0;
      dly_ff <= 3'h0;
      dstb_prev_ff <= 1'b1;
      req_valid_ff <= 1'b0;
      data_valid_ff <= 1'b0;
      addr_ff <= '0;
      cmd_ff <= '0;
      data_ff <= '0;
      snp_ff <= HBTS_SNP_NONE;
      trdy_n_ff <= 1'b1;
      rs_ff <= `HBTS_RS_IDLE;
    end
    else if (ce_i)
    begin
      req_valid_ff <= 1'b0;
      data_valid_ff <= 1'b0;
      dstb_prev_ff <= dstb_s_ff[3];
      rs_ff <= `HBTS_RS_IDLE;
      case (st_ff)
        HBTS_H_IDLE:
          if (!ads_s_ff[1] && astb_s_ff[3:2] == 2'h0)
          begin
            addr_ff <= {~ahi_s2_ff, ~alo_s2_ff};
            snp_ff <= HBTS_SNP_NONE;
            cmd_ff[4:0] <= ~cmd_s2_ff;
            st_ff <= HBTS_H_REQ2;
          end
        HBTS_H_REQ2:
          if (astb_s_ff[3:2] == 2'h3)
          begin
            cmd_ff[9:5] <= ~cmd_s2_ff;
            req_valid_ff <= 1'b1;
            st_ff <= HBTS_H_SNOOP;
          end
        HBTS_H_SNOOP:
          if (!hit_s_ff[1] || !modified_snoop_hit_s_ff[1])
          begin
            // Stall code keeps the window open and is no result
            if (!(!hit_s_ff[1] && !modified_snoop_hit_s_ff[1]))
            begin
              snp_ff <= hbts_snp_t'({~modified_snoop_hit_s_ff[1], ~hit_s_ff[1]});
              st_ff <= HBTS_H_TRDY;
            end
          end
          else if (dly_ff == `HBTS_TRDY_DLY)
            st_ff <= HBTS_H_TRDY;
          else
            dly_ff <= dly_ff + 3'h1;
        HBTS_H_TRDY:
        begin
          dly_ff <= 3'h0;
          if (data_ok_i)
          begin
            trdy_n_ff <= 1'b0;
            ph_ff <= 2'h0;
            st_ff <= HBTS_H_DATA;
          end
        end
        HBTS_H_DATA:
          if (dstb_s_ff[3] != dstb_prev_ff)
          begin
            trdy_n_ff <= 1'b1;
            data_ff[ph_ff*16 +: 16] <= inv_s2_ff[0] ? ~d_s2_ff[15:0] : d_s2_ff[15:0];
            ph_ff <= ph_ff + 2'h1;
            if (ph_ff == 2'h3)
              st_ff <= HBTS_H_RESP;
          end
        HBTS_H_RESP:
        begin
          rs_ff <= legal_rs(resp_sel_i);
          data_valid_ff <= 1'b1;
          st_ff <= HBTS_H_IDLE;
        end
        default:
          st_ff <= HBTS_H_IDLE;
      endcase
    end
endmodule : hbts_hub
`default_nettype wire

// ==== hbts_defs.svh ====
`ifndef HBTS_DEFS_SVH
`define HBTS_DEFS_SVH
`define HBTS_ADDR_W 29
`define HBTS_ADDR_LO_W 14
`define HBTS_REQ_W 5
`define HBTS_DATA_W 64
`define HBTS_GRP_N 4
`define HBTS_GRP_W 16
`define HBTS_RS_IDLE 3'h0
`define HBTS_RS_RETRY 3'h1
`define HBTS_RS_DEFER 3'h2
`define HBTS_RS_NODATA 3'h5
`define HBTS_RS_IWB 3'h6
`define HBTS_RS_NORMAL 3'h7
`define HBTS_LINK_DIV 3'h4
`define HBTS_TRDY_DLY 3'h2
`endif

// ==== hbts_pkg.sv ====
`default_nettype none
`include "hbts_defs.svh"
package hbts_pkg;
  typedef logic [`HBTS_ADDR_W-1:0] hbts_addr_t;
  typedef logic [`HBTS_REQ_W-1:0] hbts_req_t;
  typedef logic [`HBTS_DATA_W-1:0] hbts_data_t;
  typedef logic [2:0] hbts_rs_t;
  typedef enum logic [1:0]
  {
    HBTS_SNP_NONE = 2'b00,
    HBTS_SNP_CLEAN = 2'b01,
    HBTS_SNP_MOD = 2'b10,
    HBTS_SNP_STALL = 2'b11
  } hbts_snp_t;
endpackage : hbts_pkg
`default_nettype wire

// ==== hbts_if.sv ====
`timescale 1ns/1ps
`default_nettype none
interface hbts_if;
  // Wire levels, active low, inverted data and address
  logic req_strobe_n;
  logic [1:0] address_strobe_pair_n;
  logic [13:0] addr_lo_n;
  logic [14:0] addr_hi_n;
  logic [4:0] request_command_lines_n;
  logic [3:0] data_strobe_positive_n;
  logic [3:0] data_strobe_negative_n;
  logic [63:0] host_data_lines_n;
  logic [3:0] data_inversion_flags_n;
  logic bus_lock_n;
  logic clean_snoop_hit_n;
  logic modified_snoop_hit_n;
  logic target_data_ready_n;
  logic [2:0] response_status_code_n;
  modport proc (output req_strobe_n, address_strobe_pair_n, addr_lo_n, addr_hi_n, request_command_lines_n,
    data_strobe_positive_n, data_strobe_negative_n, host_data_lines_n, data_inversion_flags_n, bus_lock_n,
    clean_snoop_hit_n, modified_snoop_hit_n,
    input target_data_ready_n, response_status_code_n);
  modport hub (input req_strobe_n, address_strobe_pair_n, addr_lo_n, addr_hi_n, request_command_lines_n,
    data_strobe_positive_n, data_strobe_negative_n, host_data_lines_n, data_inversion_flags_n, bus_lock_n,
    clean_snoop_hit_n, modified_snoop_hit_n,
    output target_data_ready_n, response_status_code_n);
endinterface : hbts_if
`default_nettype wire

// ==== hbts_proc.sv ====
`timescale 1ns/1ps
`default_nettype none
`include "hbts_defs.svh"
module hbts_proc
(
  // Clock and reset
  input wire logic clk_i,
  input wire logic resetn_i,
  input wire logic ce_i,
  // User request
  input wire logic req_valid_i,
  input wire hbts_pkg::hbts_addr_t req_addr_i,
  input wire hbts_pkg::hbts_req_t req_cmd_a_i,
  input wire hbts_pkg::hbts_req_t req_cmd_b_i,
  input wire logic req_lock_i,
  input wire hbts_pkg::hbts_data_t req_data_i,
  input wire hbts_pkg::hbts_snp_t snoop_i,
  // User status
  output logic busy_o,
  output logic trdy_seen_o,
  output hbts_pkg::hbts_rs_t resp_o,
  // Link
  hbts_if.proc bus
);
  import hbts_pkg::*;
  typedef enum logic [2:0]
  {
    HBTS_P_IDLE = 3'b000,
    HBTS_P_REQ = 3'b001,
    HBTS_P_WAIT = 3'b010,
    HBTS_P_DATA = 3'b011
  } hbts_pst_t;
  hbts_pst_t st_ff;
  logic [1:0] ph_ff;
  logic [2:0] div_ff;
  hbts_addr_t addr_ff;
  hbts_req_t cmd_b_ff;
  hbts_data_t data_ff;
  logic lock_ff;
  logic [1:0] snp_ff;
  logic [1:0] trdy_s_ff;
  logic [5:0] rs_s_ff;
  logic busy_ff;
  logic trdy_seen_ff;
  hbts_rs_t resp_ff;
  wire tick = (div_ff == `HBTS_LINK_DIV - 3'h1);
  assign busy_o = busy_ff;
  assign trdy_seen_o = trdy_seen_ff;
  assign resp_o = resp_ff;
  // Sync inputs from the hub
  always_ff @(posedge clk_i or negedge resetn_i)
    if (!resetn_i)
    begin
      trdy_s_ff <= 2'h3;
      rs_s_ff <= 6'h3F;
    end
    else if (ce_i)
    begin
      trdy_s_ff <= {trdy_s_ff[0], bus.target_data_ready_n};
      rs_s_ff <= {rs_s_ff[2:0], bus.response_status_code_n};
    end
  always_ff @(posedge clk_i or negedge resetn_i)
    if (!resetn_i)
      div_ff <= 3'h0;
    else if (ce_i)
      div_ff <= tick ? 3'h0 : div_ff + 3'h1;
  always_ff @(posedge clk_i or negedge resetn_i)
    if (!resetn_i)
    begin
      st_ff <= HBTS_P_IDLE;
      ph_ff <= 2'h0;
      addr_ff <= '0;
      cmd_b_ff <= '0;
      data_ff <= '0;
      lock_ff <= 1'b0;
      snp_ff <= 2'h0;
      busy_ff <= 1'b0;
      trdy_seen_ff <= 1'b0;
      resp_ff <= `HBTS_RS_IDLE;
      bus.req_strobe_n <= 1'b1;
      bus.address_strobe_pair_n <= 2'h3;
      bus.addr_lo_n <= '1;
      bus.addr_hi_n <= '1;
      bus.request_command_lines_n <= '1;
      bus.data_strobe_positive_n <= 4'hF;
      bus.data_strobe_negative_n <= 4'h0;
      bus.host_data_lines_n <= '1;
      bus.data_inversion_flags_n <= 4'hF;
      bus.bus_lock_n <= 1'b1;
      bus.clean_snoop_hit_n <= 1'b1;
      bus.modified_snoop_hit_n <= 1'b1;
    end
    else if (ce_i)
    begin
      trdy_seen_ff <= 1'b0;
      if (rs_s_ff[5:3] != 3'h7)
        resp_ff <= ~rs_s_ff[5:3];
      case (st_ff)
        HBTS_P_IDLE:
        begin
          busy_ff <= 1'b0;
          if (!req_valid_i)
            bus.bus_lock_n <= 1'b1;
          if (req_valid_i && tick)
          begin
            busy_ff <= 1'b1;
            addr_ff <= req_addr_i;
            cmd_b_ff <= req_cmd_b_i;
            data_ff <= req_data_i;
            snp_ff <= snoop_i;
            lock_ff <= req_lock_i;
            bus.bus_lock_n <= ~req_lock_i;
            bus.req_strobe_n <= 1'b0;
            bus.addr_lo_n <= ~req_addr_i[13:0];
            bus.addr_hi_n <= ~req_addr_i[28:14];
            bus.request_command_lines_n <= ~req_cmd_a_i;
            bus.address_strobe_pair_n <= 2'h0;
            st_ff <= HBTS_P_REQ;
          end
        end
        HBTS_P_REQ:
          if (tick)
          begin
            bus.req_strobe_n <= 1'b1;
            bus.request_command_lines_n <= ~cmd_b_ff;
            bus.address_strobe_pair_n <= 2'h3;
            bus.clean_snoop_hit_n <= ~snp_ff[0];
            bus.modified_snoop_hit_n <= ~snp_ff[1];
            st_ff <= HBTS_P_WAIT;
          end
        HBTS_P_WAIT:
        begin
          if (tick)
          begin
            bus.clean_snoop_hit_n <= 1'b1;
            bus.modified_snoop_hit_n <= 1'b1;
          end
          if (!trdy_s_ff[1])
          begin
            trdy_seen_ff <= 1'b1;
            ph_ff <= 2'h0;
            st_ff <= HBTS_P_DATA;
          end
        end
        HBTS_P_DATA:
          if (tick)
          begin
            // One 16-bit slice per group and strobe edge
            for (int g = 0; g < `HBTS_GRP_N; g++)
              bus.host_data_lines_n[g*16 +: 16] <= ~data_ff[ph_ff*16 +: 16];
            bus.data_inversion_flags_n <= 4'hF;
            bus.data_strobe_positive_n <= ~bus.data_strobe_positive_n;
            bus.data_strobe_negative_n <= ~bus.data_strobe_negative_n;
            ph_ff <= ph_ff + 2'h1;
            if (ph_ff == 2'h3)
            begin
              if (!lock_ff || !req_valid_i)
                bus.bus_lock_n <= 1'b1;
              st_ff <= HBTS_P_IDLE;
            end
          end
        default:
          st_ff <= HBTS_P_IDLE;
      endcase
    end
endmodule : hbts_proc
`default_nettype wire

// ==== hbts_props.sv ====
`timescale 1ns/1ps
`default_nettype none
module hbts_props
(
  // Clock and reset
  input wire logic clk_i,
  input wire logic resetn_i,
  // Link wires
  input wire logic req_strobe_n,
  input wire logic [1:0] address_strobe_pair_n,
  input wire logic [4:0] request_command_lines_n,
  input wire logic [3:0] data_strobe_positive_n,
  input wire logic [3:0] data_strobe_negative_n,
  input wire logic [63:0] host_data_lines_n,
  input wire logic clean_snoop_hit_n,
  input wire logic modified_snoop_hit_n,
  input wire logic target_data_ready_n,
  input wire logic [2:0] response_status_code_n
);
  default clocking cb @(posedge clk_i);
  endclocking
  default disable iff (!resetn_i);
  // Wire carries the inverse of the status code
  rs_legal_a: assert property (response_status_code_n != 3'h4 && response_status_code_n != 3'h3)
    else $error("reserved status driven");
  rs_pulse_a: assert property (response_status_code_n != 3'h7 |=> response_status_code_n == 3'h7)
    else $error("status not back to idle");
  dstb_diff_a: assert property (data_strobe_positive_n == ~data_strobe_negative_n)
    else $error("data strobes not complementary");
  dstb_group_a: assert property (data_strobe_positive_n == 4'h0 || data_strobe_positive_n == 4'hf)
    else $error("data strobe groups differ");
  data_group_a: assert property ($changed(data_strobe_positive_n) |=> host_data_lines_n[15:0] ==
    host_data_lines_n[31:16] && host_data_lines_n[47:32] == host_data_lines_n[63:48])
    else $error("data groups differ");
  ads_width_a: assert property ($fell(req_strobe_n) |-> !req_strobe_n [*4] ##1 req_strobe_n)
    else $error("request strobe width wrong");
  addr_strobe_a: assert property ($fell(req_strobe_n) |-> address_strobe_pair_n == 2'h0 ##4
    address_strobe_pair_n == 2'h3)
    else $error("address strobes wrong");
  cmd_hold_a: assert property ($fell(req_strobe_n) |=> $stable(request_command_lines_n) [*3])
    else $error("command lines moved in first half");
  snoop_stall_a: assert property (!clean_snoop_hit_n && !modified_snoop_hit_n |-> target_data_ready_n)
    else $error("target ready during snoop stall");
  trdy_data_a: assert property ($fell(target_data_ready_n) |-> ##[1:12] $changed(data_strobe_positive_n))
    else $error("no data after target ready");
  cover property ($fell(req_strobe_n));
  cover property (!clean_snoop_hit_n && !modified_snoop_hit_n);
  cover property (response_status_code_n == 3'h0);
endmodule : hbts_props
`default_nettype wire

// ==== tb_host_bus_target_signaling.sv ====
`timescale 1ns/1ps
`default_nettype none
module tb_host_bus_target_signaling;
  import hbts_pkg::*;
  logic clk_i = 1'b0;
  logic resetn_i = 1'b0;
  logic req_valid_i = 1'b0;
  hbts_addr_t req_addr_i = '0;
  hbts_req_t req_cmd_a_i = '0;
  hbts_req_t req_cmd_b_i = '0;
  logic req_lock_i = 1'b0;
  hbts_data_t req_data_i = '0;
  hbts_snp_t snoop_i = HBTS_SNP_NONE;
  logic data_ok_i = 1'b1;
  hbts_rs_t resp_sel_i = 3'h7;
  logic hub_snoop_req_i = 1'b0;
  logic busy_o, trdy_seen_o, hub_snoop_gnt_o, req_valid_o, data_valid_o;
  hbts_rs_t resp_o;
  hbts_addr_t req_addr_o, cap_addr;
  logic [9:0] req_cmd_o, cap_cmd;
  hbts_data_t data_o, cap_dat;
  hbts_snp_t snoop_o, cap_snp;
  logic got_req = 1'b0, got_dat = 1'b0, got_trdy = 1'b0, gnt_at_req = 1'b0;
  int fail_count = 0;
  int cmp_count = 0;
  hbts_if bus ();
  always #10 clk_i = ~clk_i;
  hbts_proc hbts_proc_i (.clk_i(clk_i), .resetn_i(resetn_i), .ce_i(1'b1), .req_valid_i(req_valid_i),
    .req_addr_i(req_addr_i), .req_cmd_a_i(req_cmd_a_i), .req_cmd_b_i(req_cmd_b_i), .req_lock_i(req_lock_i),
    .req_data_i(req_data_i), .snoop_i(snoop_i), .busy_o(busy_o), .trdy_seen_o(trdy_seen_o), .resp_o(resp_o),
    .bus(bus));
  hbts_hub hbts_hub_i (.clk_i(clk_i), .resetn_i(resetn_i), .ce_i(1'b1), .data_ok_i(data_ok_i),
    .resp_sel_i(resp_sel_i), .hub_snoop_req_i(hub_snoop_req_i), .hub_snoop_gnt_o(hub_snoop_gnt_o),
    .req_valid_o(req_valid_o), .req_addr_o(req_addr_o), .req_cmd_o(req_cmd_o), .data_o(data_o),
    .data_valid_o(data_valid_o), .snoop_o(snoop_o), .bus(bus));
  hbts_props hbts_props_i (.clk_i(clk_i), .resetn_i(resetn_i), .req_strobe_n(bus.req_strobe_n),
    .address_strobe_pair_n(bus.address_strobe_pair_n), .request_command_lines_n(bus.request_command_lines_n),
    .data_strobe_positive_n(bus.data_strobe_positive_n), .data_strobe_negative_n(bus.data_strobe_negative_n),
    .host_data_lines_n(bus.host_data_lines_n), .clean_snoop_hit_n(bus.clean_snoop_hit_n),
    .modified_snoop_hit_n(bus.modified_snoop_hit_n), .target_data_ready_n(bus.target_data_ready_n),
    .response_status_code_n(bus.response_status_code_n));
  // One-cycle pulses are caught here so tasks never miss them
  always @(posedge clk_i)
  begin
    if (req_valid_o)
    begin
      got_req <= 1'b1;
      cap_addr <= req_addr_o;
      cap_cmd <= req_cmd_o;
      gnt_at_req <= hub_snoop_gnt_o;
    end
    if (data_valid_o)
    begin
      got_dat <= 1'b1;
      cap_dat <= data_o;
      cap_snp <= snoop_o;
    end
    if (trdy_seen_o)
      got_trdy <= 1'b1;
  end
  task automatic check(input logic [63:0] seen, input logic [63:0] exp, input string msg);
    cmp_count++;
    if (seen !== exp)
    begin
      fail_count++;
      $display("CHECK FAILED %0t %s", $time, msg);
    end
  endtask : check
  task automatic end_sim;
    if (fail_count == 0 && cmp_count > 0)
      $display("No errors found");
    else
      $display("Errors were found");
    $finish;
  endtask : end_sim
  task automatic launch(input hbts_addr_t a, input hbts_req_t ca, input hbts_req_t cb, input logic lk,
    input hbts_data_t d, input hbts_snp_t s);
    int k;
    got_req = 1'b0;
    got_dat = 1'b0;
    got_trdy = 1'b0;
    req_addr_i = a;
    req_cmd_a_i = ca;
    req_cmd_b_i = cb;
    req_lock_i = lk;
    req_data_i = d;
    snoop_i = s;
    req_valid_i = 1'b1;
    for (k = 0; k < 40 && bus.req_strobe_n !== 1'b0; k++)
      @(negedge clk_i);
    req_valid_i = 1'b0;
    check(bus.addr_lo_n, {~a[13:0]}, "wire addr lo");
    check(bus.addr_hi_n, {~a[28:14]}, "wire addr hi");
    check(bus.request_command_lines_n, {~ca}, "wire cmd a");
    check(bus.bus_lock_n, !lk, "wire lock");
    for (k = 0; k < 10 && bus.address_strobe_pair_n !== 2'h3; k++)
      @(negedge clk_i);
    check(bus.request_command_lines_n, {~cb}, "wire cmd b");
  endtask : launch
  task automatic run_txn(input hbts_addr_t a, input hbts_req_t ca, input hbts_req_t cb, input logic lk,
    input hbts_data_t d, input hbts_snp_t s, input hbts_rs_t rsel);
    int k;
    resp_sel_i = rsel;
    launch(a, ca, cb, lk, d, s);
    for (k = 0; k < 600 && (busy_o !== 1'b0 || got_dat !== 1'b1); k++)
      @(negedge clk_i);
    // Status crosses two sync stages before resp_o
    repeat (3) @(negedge clk_i);
    check({got_req, got_dat, got_trdy}, 3'h7, "transfer incomplete");
    check(cap_addr, a, "addr");
    check(cap_cmd, {cb, ca}, "cmd");
    check(cap_dat, d, "data");
    check(cap_snp, (s == HBTS_SNP_STALL) ? HBTS_SNP_NONE : s, "snoop");
    check(resp_o, (rsel == 3'h0 || rsel == 3'h3 || rsel == 3'h4) ? 3'h7 : rsel, "resp");
  endtask : run_txn
  initial
  begin
    repeat (6) @(negedge clk_i);
    resetn_i = 1'b1;
    hub_snoop_req_i = 1'b1;
    repeat (3) @(negedge clk_i);
    check(hub_snoop_gnt_o, 1'b1, "gnt idle");
    // Every status code including illegal ones, back to back
    for (int i = 0; i < 8; i++)
    begin
      if (i == 1)
        data_ok_i = 1'b0;
      fork
        run_txn({29{i[0]}} ^ 29'(i * 13), 5'(i), 5'(31 - i), i == 0, 64'h0123_4567_89ab_cdef ^ {8{8'(i)}},
          hbts_snp_t'(2'(i % 3)), 3'(i));
        if (i == 1)
        begin
          repeat (30) @(negedge clk_i);
          check(bus.target_data_ready_n, 1'b1, "trdy early");
          check(got_trdy, 1'b0, "trdy seen early");
          data_ok_i = 1'b1;
        end
      join
      if (i == 0)
        check(gnt_at_req, 1'b0, "gnt in lock");
    end
    for (int k = 0; k < 100 && hub_snoop_gnt_o !== 1'b1; k++)
      @(negedge clk_i);
    check(hub_snoop_gnt_o, 1'b1, "gnt after lock");
    // Stall holds the hub in snoop a while and is no snoop result
    fork
      run_txn(29'h1234_5678, 5'h1f, 5'h00, 1'b0, 64'hffff_0000_ffff_0000, HBTS_SNP_STALL, 3'h1);
      begin
        wait (bus.clean_snoop_hit_n === 1'b0);
        repeat (9) @(negedge clk_i);
        check(got_dat, 1'b0, "data in stall");
        check(bus.target_data_ready_n, 1'b1, "trdy in stall");
        check(snoop_o, HBTS_SNP_NONE, "stall taken as result");
      end
    join
    // Reset in mid-transfer
    launch(29'h0000_0abc, 5'h03, 5'h1c, 1'b0, 64'h0f0f_0f0f_0f0f_0f0f, HBTS_SNP_NONE);
    repeat (5) @(negedge clk_i);
    resetn_i = 1'b0;
    repeat (6) @(negedge clk_i);
    resetn_i = 1'b1;
    check(bus.response_status_code_n, 3'h7, "rs idle");
    run_txn(29'h0000_0001, 5'h0a, 5'h15, 1'b0, 64'h8000_0000_0000_0001, HBTS_SNP_MOD, 3'h5);
    end_sim();
  end
  initial
  begin
    repeat (20000) @(posedge clk_i);
    fail_count++;
    end_sim();
  end
endmodule : tb_host_bus_target_signaling
`default_nettype wire
